// ==== cirs_regs.svh ====
// timing counts and reset values for the init / run-stop control block
`ifndef CIRS_REGS_SVH
`define CIRS_REGS_SVH
`define CIRS_INIT_PULSE_CYC 4'h4
`define CIRS_SYNC_RST 2'h0
`define CIRS_SYNC_IDLE_HI 2'h3
`define CIRS_DISC_RST 4'h0
`define CIRS_RUN_ARM_BIT 0
`define CIRS_RUN_BIT 1
`define CIRS_FETCH_BIT 2
`define CIRS_DEFER_BIT 3
`define CIRS_PTG_W 2
`define CIRS_PTG2 2'h2
`define CIRS_PTG3 2'h3
`endif

// ==== cirs_pkg.sv ====
// shared types for the init / run-stop control block
package cirs_pkg;
  typedef enum logic [1:0] {
    CIRS_PTG0 = 2'b00,
    CIRS_PTG1 = 2'b01,
    CIRS_PTG2S = 2'b11,
    CIRS_PTG3S = 2'b10
  } cirs_ptg_t;
endpackage

// ==== cirs_discretes.sv ====
// four-stage state-discretes register with load, left shift and master clear
`timescale 1ns/1ps
`include "cirs_regs.svh"
module cirs_discretes #(
  parameter int WIDTH = 4
) (
  // clock and master clear
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic master_clear_input_i,
  // per-stage load
  input wire logic [WIDTH-1:0] load_i,
  input wire logic [WIDTH-1:0] d_i,
  // shift
  input wire logic shift_i,
  input wire logic serial_shift_in_i,
  // stage outputs
  output logic [WIDTH-1:0] q_o
);
  // master clear acts without the clock, like the async reset
  always_ff @(negedge sys_clk_i or negedge rst_n_i or posedge master_clear_input_i) begin // R1
    if (!rst_n_i || master_clear_input_i) begin
      q_o <= '0; // R6
    end else if (shift_i) begin
      q_o <= {q_o[WIDTH-2:0], serial_shift_in_i}; // R12
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (load_i[i]) begin
          q_o[i] <= d_i[i]; // R11
        end
      end
    end
  end
endmodule

// ==== cirs_init_pulse.sv ====
// rising-edge detector that emits a fixed-length initialization pulse
`timescale 1ns/1ps
`include "cirs_regs.svh"
module cirs_init_pulse (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // source level (already synchronised)
  input wire logic level_i,
  // pulse out
  output logic pulse_o
);
  logic level_d_r;
  logic [3:0] cnt_r;
  always_ff @(negedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_d_r <= 1'b0;
    end else begin
      level_d_r <= level_i;
    end
  end
  always_ff @(negedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 4'h0;
      pulse_o <= 1'b0;
    end else if (level_i && !level_d_r) begin
      cnt_r <= `CIRS_INIT_PULSE_CYC - 4'h1; // R20
      pulse_o <= 1'b1;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end else begin
      pulse_o <= 1'b0;
    end
  end
endmodule

// ==== cirs_ctrl.sv ====
// processor init and run/stop control
// Contract
// R1 - all clocked logic acts on the falling clock edge with its enables
// R2 - supply-good rising edge makes one pulse on reset and pre-init
// R3 - supply-good and console reset are combined to launch init pulses
// R4 - console reset press starts a synchronous clear of run; here run is cleared by the asynchronous master clear
// R5 - console reset release produces reset and pre-init pulses
// R6 - reset pulse master-clears the discretes register including run
// R7 - halt request when reset, logic good, memory good or key tree low
// R8 - reset or logic loss clears at once; stop key waits for instruction end
// R9 - halt request or halt decode loads zero into run-arm
// R10 - run-arm clears at state 2; run clears at next state 3 edge
// R11 - each discretes stage loads independently on strobe plus clock edge
// R12 - shift-wired discretes shift serial input in on enabled clocks
// R13 - no new memory cycle start while run-arm is clear
// R14 - no timing-state signals while run is clear
// R15 - after power-on init machine stays stopped until console starts it
// R16 - stopped: address display shows buffer out bus
// R17 - running: data display shows memory bus
// R18 - carry, run, int enable, fetch, defer, execute shown on console
// R19 - console reset clears io flags, int enable, sets supervisor, line freq
// R20 - edges synchronised; init pulses fixed length, at least one clock
`timescale 1ns/1ps
`include "cirs_regs.svh"
module cirs_ctrl
  import cirs_pkg::*;
#(
  parameter int DATA_W = 16
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // supply monitors and console lines (halt sources low active; start key and halt decode high active)
  input wire logic logic_ok_i,
  input wire logic mem_ok_i,
  input wire logic console_rst_n_i,
  input wire logic key_tree_i,
  input wire logic start_key_i,
  input wire logic halt_decode_i,
  // processor state to display
  input wire logic carry_i,
  input wire logic int_enable_i,
  input wire logic execute_i,
  input wire logic fetch_set_i,
  input wire logic defer_set_i,
  input wire logic [DATA_W-1:0] buffer_out_bus_i,
  input wire logic [DATA_W-1:0] memory_bus_i,
  // init pulses
  output logic reset_o,
  output logic preset_o,
  // console-reset side effects
  output logic io_flags_clr_o,
  output logic int_enable_clr_o,
  output logic supervisor_o,
  output logic line_freq_sel_o,
  // timing
  output logic halt_request_o,
  output logic mem_cycle_start_o,
  output logic [`CIRS_PTG_W-1:0] proc_timing_state_o,
  output logic ptg_valid_o,
  // console display
  output logic [DATA_W-1:0] addr_disp_o,
  output logic [DATA_W-1:0] data_disp_o,
  output logic carry_o,
  output logic run_o,
  output logic ion_o,
  output logic fetch_o,
  output logic defer_o,
  output logic execute_o
);
  // two-flop synchronisers; first stage read only by the second
  logic [1:0] lok_s_r, mok_s_r, crst_s_r, key_s_r;
  always_ff @(negedge sys_clk_i or negedge rst_n_i) begin // R1
    if (!rst_n_i) begin
      lok_s_r <= `CIRS_SYNC_RST;
      mok_s_r <= `CIRS_SYNC_RST;
      crst_s_r <= `CIRS_SYNC_IDLE_HI;
      key_s_r <= `CIRS_SYNC_IDLE_HI;
    end else begin
      lok_s_r <= {lok_s_r[0], logic_ok_i}; // R20
      mok_s_r <= {mok_s_r[0], mem_ok_i};
      crst_s_r <= {crst_s_r[0], console_rst_n_i};
      key_s_r <= {key_s_r[0], key_tree_i};
    end
  end
  wire logic lok = lok_s_r[1];
  wire logic mok = mok_s_r[1];
  wire logic crst_n = crst_s_r[1];
  wire logic keyt = key_s_r[1];

  // supply-good and console reset combined; a rising edge of either while the other is high launches init
  logic init_src;
  logic init_pulse;
  always_comb begin
    init_src = lok & crst_n; // R3
  end
  cirs_init_pulse u_pulse (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .level_i(init_src),
    .pulse_o(init_pulse)
  );

  logic crst_d_r;
  always_ff @(negedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crst_d_r <= 1'b1;
    end else begin
      crst_d_r <= crst_n;
    end
  end
  wire logic crst_release = crst_n & ~crst_d_r;

  always_ff @(negedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reset_o <= 1'b1;
      preset_o <= 1'b1;
    end else begin
      reset_o <= init_pulse; // R2 R5
      preset_o <= init_pulse;
    end
  end

  // console reset side effects
  always_ff @(negedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_flags_clr_o <= 1'b1;
      int_enable_clr_o <= 1'b1;
      supervisor_o <= 1'b1;
      line_freq_sel_o <= 1'b1;
    end else begin
      io_flags_clr_o <= ~crst_n | init_pulse; // R19
      int_enable_clr_o <= ~crst_n | init_pulse;
      if (!crst_n || init_pulse) begin
        supervisor_o <= 1'b1; // R19
        line_freq_sel_o <= 1'b1;
      end else if (start_key_i) begin
        supervisor_o <= 1'b0;
        line_freq_sel_o <= 1'b0;
      end
    end
  end

  // halt request from any low source
  logic halt_rq;
  always_comb begin
    halt_rq = ~crst_n | ~lok | ~mok | ~keyt; // R7
  end
  always_ff @(negedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      halt_request_o <= 1'b1;
    end else begin
      halt_request_o <= halt_rq;
    end
  end

  // timing state walker; runs only while run is set
  cirs_ptg_t ptg_r;
  logic [3:0] disc_q;
  logic run_arm, run;
  assign run_arm = disc_q[`CIRS_RUN_ARM_BIT];
  assign run = disc_q[`CIRS_RUN_BIT];

  always_ff @(negedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptg_r <= CIRS_PTG0;
    end else if (!run) begin
      ptg_r <= CIRS_PTG0; // R14
    end else begin
      case (ptg_r)
        CIRS_PTG0: ptg_r <= CIRS_PTG1;
        CIRS_PTG1: ptg_r <= CIRS_PTG2S;
        CIRS_PTG2S: ptg_r <= CIRS_PTG3S;
        CIRS_PTG3S: ptg_r <= CIRS_PTG0;
        default: ptg_r <= CIRS_PTG0;
      endcase
    end
  end
  logic [1:0] ptg_num;
  always_comb begin
    case (ptg_r)
      CIRS_PTG0: ptg_num = 2'h0;
      CIRS_PTG1: ptg_num = 2'h1;
      CIRS_PTG2S: ptg_num = `CIRS_PTG2;
      CIRS_PTG3S: ptg_num = `CIRS_PTG3;
      default: ptg_num = 2'h0;
    endcase
  end
  wire logic at_ptg2 = run & (ptg_num == `CIRS_PTG2);
  wire logic at_ptg3 = run & (ptg_num == `CIRS_PTG3);

  // halt latch: stop key waits, reset / logic loss act at once
  logic stop_pend_r;
  wire logic immediate = ~crst_n | ~lok; // R8
  always_ff @(negedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stop_pend_r <= 1'b0;
    end else if (halt_rq || halt_decode_i) begin
      stop_pend_r <= 1'b1; // R9
    end else if (start_key_i) begin
      stop_pend_r <= 1'b0;
    end
  end

  // discretes loads: run-arm cleared at ptg2, run cleared at ptg3 after that
  logic [3:0] ld, dv;
  logic shift_en;
  always_comb begin
    ld = 4'h0;
    dv = 4'h0;
    shift_en = 1'b0;
    if (start_key_i && !run && !halt_rq) begin
      ld[`CIRS_RUN_ARM_BIT] = 1'b1; // R15
      dv[`CIRS_RUN_ARM_BIT] = 1'b1;
      shift_en = 1'b1; // R12
    end else if (stop_pend_r && at_ptg2) begin
      ld[`CIRS_RUN_ARM_BIT] = 1'b1; // R10
    end
    if (!run_arm && at_ptg3) begin
      ld[`CIRS_RUN_BIT] = 1'b1; // R10
    end
    if (run && ptg_num == `CIRS_PTG3) begin
      ld[`CIRS_FETCH_BIT] = 1'b1; // R11
      ld[`CIRS_DEFER_BIT] = 1'b1;
      dv[`CIRS_FETCH_BIT] = fetch_set_i;
      dv[`CIRS_DEFER_BIT] = defer_set_i;
    end
  end
  // init pulse, and immediate stop while reset_o is low, both master-clear the discretes
  wire logic mclr = init_pulse | (immediate & ~reset_o); // R4 R6 R8
  cirs_discretes #(.WIDTH(4)) u_disc (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .master_clear_input_i(mclr),
    .load_i(ld),
    .d_i(dv),
    .shift_i(shift_en),
    .serial_shift_in_i(1'b1),
    .q_o(disc_q)
  );

  // timing outputs and displays
  always_ff @(negedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_cycle_start_o <= 1'b0;
      proc_timing_state_o <= 2'h0;
      ptg_valid_o <= 1'b0;
    end else begin
      mem_cycle_start_o <= run_arm & run & (ptg_r == CIRS_PTG3S); // R13
      proc_timing_state_o <= run ? ptg_num : 2'h0; // R14
      ptg_valid_o <= run;
    end
  end
  always_ff @(negedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_disp_o <= '0;
      data_disp_o <= '0;
    end else begin
      if (!run) begin
        addr_disp_o <= buffer_out_bus_i; // R16
      end
      if (run) begin
        data_disp_o <= memory_bus_i; // R17
      end
    end
  end
  always_ff @(negedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      carry_o <= 1'b0;
      run_o <= 1'b0;
      ion_o <= 1'b0;
      fetch_o <= 1'b0;
      defer_o <= 1'b0;
      execute_o <= 1'b0;
    end else begin
      carry_o <= carry_i; // R18
      run_o <= run;
      ion_o <= int_enable_i;
      fetch_o <= disc_q[`CIRS_FETCH_BIT];
      defer_o <= disc_q[`CIRS_DEFER_BIT];
      execute_o <= execute_i;
    end
  end

  property p_halt_src;
    @(negedge sys_clk_i) disable iff (!rst_n_i)
      (!crst_n || !lok || !mok || !keyt) |=> halt_request_o;
  endproperty
  a_halt_src: assert property (p_halt_src) else $error("halt request missing"); // R7
  property p_ptg_gated;
    @(negedge sys_clk_i) disable iff (!rst_n_i)
      !run |=> (!ptg_valid_o && proc_timing_state_o == 2'h0);
  endproperty
  a_ptg_gated: assert property (p_ptg_gated) else $error("timing while stopped"); // R14
  property p_mem_gate;
    @(negedge sys_clk_i) disable iff (!rst_n_i)
      !run_arm |=> !mem_cycle_start_o;
  endproperty
  a_mem_gate: assert property (p_mem_gate) else $error("memory start w/o arm"); // R13
  property p_run_clear;
    @(negedge sys_clk_i) disable iff (!rst_n_i)
      (!run_arm && at_ptg3 && !mclr) |=> !run;
  endproperty
  a_run_clear: assert property (p_run_clear) else $error("run not cleared"); // R10
  property p_arm_clear;
    @(negedge sys_clk_i) disable iff (!rst_n_i)
      (stop_pend_r && at_ptg2 && !start_key_i) |=> !run_arm;
  endproperty
  a_arm_clear: assert property (p_arm_clear) else $error("arm not cleared"); // R9
  property p_init_run;
    @(negedge sys_clk_i) disable iff (!rst_n_i)
      init_pulse |=> (!run && !run_arm);
  endproperty
  a_init_run: assert property (p_init_run) else $error("run after init"); // R6
  property p_pulse_len;
    @(negedge sys_clk_i) disable iff (!rst_n_i)
      $rose(init_pulse) |-> init_pulse[*4] ##1 !init_pulse;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong"); // R20
  property p_rst_clear;
    @(negedge sys_clk_i) disable iff (!rst_n_i)
      !crst_n |=> (io_flags_clr_o && int_enable_clr_o && supervisor_o);
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("reset effects missing"); // R19
  property p_release;
    @(negedge sys_clk_i) disable iff (!rst_n_i)
      (crst_release && lok) |=> ##[1:2] reset_o;
  endproperty
  a_release: assert property (p_release) else $error("no pulse on release"); // R5
  property p_addr;
    @(negedge sys_clk_i) disable iff (!rst_n_i)
      !run |=> addr_disp_o == $past(buffer_out_bus_i);
  endproperty
  a_addr: assert property (p_addr) else $error("address display wrong"); // R16
  // without a master clear, run may only drop at the state 3 edge
  property p_run_hold;
    @(negedge sys_clk_i) disable iff (!rst_n_i)
      (run && !at_ptg3) ##1 !mclr |-> run;
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("run dropped outside state 3"); // R8

  c_run: cover property (@(negedge sys_clk_i) disable iff (!rst_n_i) $rose(run));
  c_stop: cover property (@(negedge sys_clk_i) disable iff (!rst_n_i) $fell(run));
  c_init: cover property (@(negedge sys_clk_i) disable iff (!rst_n_i) $rose(reset_o));
  c_halt_dec: cover property (@(negedge sys_clk_i) disable iff (!rst_n_i) halt_decode_i && run);
endmodule

// ==== cirs_console_model.sv ====
// supply monitors and operator console switches facing the control block
`timescale 1ns/1ps
module cirs_console_model #(
  parameter int RAMP_CYC = 3
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // supply and operator commands
  input wire logic power_on_i,
  input wire logic mem_fail_i,
  input wire logic rst_press_i,
  input wire logic stop_press_i,
  input wire logic start_press_i,
  // lines to the processor
  output logic logic_ok_o,
  output logic mem_ok_o,
  output logic console_rst_n_o,
  output logic key_tree_o,
  output logic start_key_o
);
  int ramp_r;

  // good drops at once on loss but rises only after the rail settles
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ramp_r <= 0;
      logic_ok_o <= 1'h0;
    end else if (!power_on_i) begin
      ramp_r <= 0;
      logic_ok_o <= 1'h0;
    end else if (ramp_r < RAMP_CYC) begin
      ramp_r <= ramp_r + 1;
    end else begin
      logic_ok_o <= 1'h1;
    end
  end

  // memory rail follows logic good one clock later, and a memory fail holds it low
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_ok_o <= 1'h0;
    end else begin
      mem_ok_o <= logic_ok_o & ~mem_fail_i;
    end
  end

  // switches are already debounced; released reset and stop keys rest high, start key rests low
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      console_rst_n_o <= 1'h1;
      key_tree_o <= 1'h1;
      start_key_o <= 1'h0;
    end else begin
      console_rst_n_o <= ~rst_press_i;
      key_tree_o <= ~stop_press_i;
      start_key_o <= start_press_i;
    end
  end
endmodule

// ==== cirs_ctrl_tb_top.sv ====
// self-checking bench for the init and run/stop control block
`timescale 1ns/1ps
`include "cirs_regs.svh"
module cirs_ctrl_tb_top;
  import cirs_pkg::*;
  logic sys_clk, rst_n, power_on, mem_fail, rst_press, stop_press, start_press, halt_dec;
  logic carry, int_en, execute, fetch_set, defer_set;
  logic [15:0] bo_bus, mem_bus, addr_disp, data_disp;
  logic logic_ok, mem_ok, console_rst_n, key_tree, start_key;
  logic reset, preset, io_clr, ie_clr, superv, line_freq, halt_req, mcs, ptg_valid;
  logic carry_l, run, ion, fetch, defer, exec_l;
  logic [`CIRS_PTG_W-1:0] proc_timing_state;
  int fails, checked;

  always #25 sys_clk = ~sys_clk;

  cirs_console_model model (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .power_on_i(power_on),
    .mem_fail_i(mem_fail), .rst_press_i(rst_press), .stop_press_i(stop_press),
    .start_press_i(start_press), .logic_ok_o(logic_ok), .mem_ok_o(mem_ok),
    .console_rst_n_o(console_rst_n), .key_tree_o(key_tree), .start_key_o(start_key));

  cirs_ctrl #(.DATA_W(16)) uut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .logic_ok_i(logic_ok),
    .mem_ok_i(mem_ok), .console_rst_n_i(console_rst_n), .key_tree_i(key_tree),
    .start_key_i(start_key), .halt_decode_i(halt_dec), .carry_i(carry), .int_enable_i(int_en),
    .execute_i(execute), .fetch_set_i(fetch_set), .defer_set_i(defer_set),
    .buffer_out_bus_i(bo_bus), .memory_bus_i(mem_bus), .reset_o(reset), .preset_o(preset),
    .io_flags_clr_o(io_clr), .int_enable_clr_o(ie_clr), .supervisor_o(superv),
    .line_freq_sel_o(line_freq), .halt_request_o(halt_req), .mem_cycle_start_o(mcs),
    .proc_timing_state_o(proc_timing_state), .ptg_valid_o(ptg_valid), .addr_disp_o(addr_disp),
    .data_disp_o(data_disp), .carry_o(carry_l), .run_o(run), .ion_o(ion), .fetch_o(fetch),
    .defer_o(defer), .execute_o(exec_l));

  task automatic test_done;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %0s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chkw(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %0s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chkn(input int got, input int exp, input string what);
    checked++;
    if (got != exp) begin
      fails++;
      $display("[ERR] %0t %0s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: pick = reset;
      1: pick = run;
      2: pick = halt_req;
      3: pick = mcs;
      4: pick = fetch;
      default: pick = preset;
    endcase
  endfunction

  // bounded wait; running out ends the run through the closing report
  task automatic wait_for(input int s, input logic v, input int lim);
    int n = 0;
    while (pick(s) !== v && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    if (pick(s) !== v) begin
      fails++;
      $display("[ERR] %0t wait on %0d ran out", $time, s);
      test_done();
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic pulse_check;
    int np = 0;
    int nr = 0;
    wait_for(5, 1'h1, 20);
    repeat (12) begin
      if (preset === 1'h1) np++;
      if (reset === 1'h1) nr++;
      @(posedge sys_clk);
    end
    chkn(np, int'(`CIRS_INIT_PULSE_CYC), "preset length");
    chkn(nr, int'(`CIRS_INIT_PULSE_CYC), "reset length");
  endtask

  task automatic start_run;
    start_press <= 1'h1;
    wait_for(1, 1'h1, 20);
    start_press <= 1'h0;
    tick(8);
  endtask

  task automatic count_mcs(output int n);
    n = 0;
    repeat (10) begin
      @(posedge sys_clk);
      if (mcs === 1'h1) n++;
    end
  endtask

  initial begin
    int n;
    sys_clk = 1'h0;
    rst_n = 1'h0;
    {power_on, mem_fail, rst_press, stop_press, start_press, halt_dec} = 6'h00;
    {carry, int_en, execute, fetch_set, defer_set} = 5'h00;
    bo_bus = 16'h0000;
    mem_bus = 16'h0000;
    fails = 0;
    checked = 0;
    tick(16);
    rst_n <= 1'h1;
    wait_for(0, 1'h0, 20);
    power_on <= 1'h1;
    pulse_check();
    tick(10);
    chk1(run, 1'h0, "stopped after init");
    chk1(ptg_valid, 1'h0, "no timing when stopped");
    chk1(halt_req, 1'h0, "no halt when all good");
    bo_bus <= 16'h1234;
    tick(4);
    chkw(addr_disp, 16'h1234, "address display");
    $display("test power_on done");
    carry <= 1'h1;
    int_en <= 1'h1;
    execute <= 1'h1;
    mem_bus <= 16'ha5c3;
    start_run();
    wait_for(3, 1'h1, 8);
    chkw({14'h0000, proc_timing_state}, {14'h0000, `CIRS_PTG3}, "memory start in state 3");
    chk1(ptg_valid, 1'h1, "timing while running");
    chkw(data_disp, 16'ha5c3, "data display");
    chk1(carry_l, 1'h1, "carry light");
    chk1(ion, 1'h1, "interrupt light");
    chk1(exec_l, 1'h1, "execute light");
    chk1(superv, 1'h0, "start leaves supervisor");
    fetch_set <= 1'h1;
    defer_set <= 1'h1;
    wait_for(4, 1'h1, 12);
    chk1(defer, 1'h1, "defer light");
    $display("test start done");
    stop_press <= 1'h1;
    wait_for(2, 1'h1, 10);
    chk1(run, 1'h1, "stop key waits for instruction end");
    wait_for(1, 1'h0, 30);
    stop_press <= 1'h0;
    chk1(ptg_valid, 1'h0, "timing off after stop");
    chkw({14'h0000, proc_timing_state}, 16'h0000, "timing state idle");
    count_mcs(n);
    chkn(n, 0, "no memory cycle when stopped");
    $display("test stop_key done");
    mem_fail <= 1'h1;
    tick(6);
    chk1(halt_req, 1'h1, "memory supply loss");
    start_press <= 1'h1;
    tick(10);
    chk1(run, 1'h0, "start refused while halt source low");
    start_press <= 1'h0;
    mem_fail <= 1'h0;
    tick(6);
    $display("test mem_loss done");
    start_run();
    halt_dec <= 1'h1;
    tick(1);
    halt_dec <= 1'h0;
    wait_for(1, 1'h0, 30);
    $display("test halt done");
    start_run();
    rst_press <= 1'h1;
    wait_for(1, 1'h0, 8);
    tick(3);
    chk1(io_clr, 1'h1, "io flags cleared");
    chk1(ie_clr, 1'h1, "interrupt enable cleared");
    chk1(halt_req, 1'h1, "console reset halts");
    rst_press <= 1'h0;
    pulse_check();
    chk1(superv, 1'h1, "supervisor mode");
    chk1(line_freq, 1'h1, "line frequency");
    chk1(run, 1'h0, "stopped after console reset");
    $display("test console_reset done");
    start_run();
    power_on <= 1'h0;
    wait_for(1, 1'h0, 8);
    power_on <= 1'h1;
    pulse_check();
    $display("test logic_loss done");
    test_done();
  end
endmodule
